// ==== pkg/trim_cal_pkg.sv ====
// Constants shared by the offset trim calibration controller
package trim_cal_pkg;
  // ----------------------------------------------------------------
  // Trim widths and reset values
  // ----------------------------------------------------------------
  localparam int AMP_TRIM_W = 6;
  localparam int CMP_TRIM_W = 5;
  localparam int NUM_AMPS = 2;
  localparam logic [5:0] AMP_TRIM_RST = 6'h20;
  localparam logic [4:0] CMP_TRIM_RST = 5'h10;
  // ----------------------------------------------------------------
  // Settling time after each trim write
  // ----------------------------------------------------------------
  localparam int SETTLE_NS = 1000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // Controller register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h1;
  localparam logic [3:0] RES_OFS = 4'h2;
  localparam logic [3:0] TRIM_OFS = 4'h3;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_TGT_LSB = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_EDGE_LO_BIT = 2;
  localparam int STAT_EDGE_HI_BIT = 3;
  localparam logic [1:0] TGT_CMP = 2'h2;
  // Sequencer states, Gray coded in listed order, ST_SETTLE aside
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_MODE = 4'h1,
    ST_REF = 4'h3,
    ST_ZERO = 4'h2,
    ST_UP = 4'h6,
    ST_ONES = 4'h7,
    ST_DOWN = 4'h5,
    ST_FINISH = 4'h4,
    ST_SETTLE = 4'hC
  } cal_state_e;
endpackage

// ==== src/settle_timer.sv ====
// Settling delay counter for trim writes
`timescale 1ns/1ps
module settle_timer #(
  parameter int CYCLES = 200
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic start,
  output logic done
);
  // ----------------------------------------------------------------
  // Down counter
  // ----------------------------------------------------------------
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_q; // Remaining cycles
  logic [CW-1:0] cnt_d;
  logic done_q; // Expiry pulse
  logic done_d;
  // Refuse a count that would never expire
  if (CYCLES < 1) begin : g_bad_cycles
    $error("settle_timer needs CYCLES >= 1");
  end
  // Next count
  always_comb begin
    cnt_d = cnt_q;
    done_d = 1'b0;
    if (start) begin
      cnt_d = CW'(CYCLES);
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
      done_d = (cnt_q == CW'(1));
    end
  end
  // Registers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end
  assign done = done_q;
endmodule // settle_timer

// ==== src/trim_cal_ctrl.sv ====
// Offset trim calibration controller for amplifiers and comparator
// Function
// - Set calibration mode before reference select
// - Pin sharing set for amplifier inputs first
// - Amplifier: mode 1, reference select 1
// - Amplifier trim zero, sample start state
// - Step up until output flips, record
// - Amplifier trim all ones, resample state
// - Step down until output flips, record
// - Amplifier trim gets truncated crossing average
// - Comparator: mode 1, reference select 1
// - Comparator trim zero, sample start state
// - Comparator step up until flip, record
// - Comparator trim all ones, resample
// - Comparator step down until flip, record
// - Comparator trim gets truncated average
`timescale 1ns/1ps
module trim_cal_ctrl #(
  parameter int SETTLE_CYCLES = trim_cal_pkg::SETTLE_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic [trim_cal_pkg::NUM_AMPS-1:0] amp_cal_mode_sel,
  output logic [trim_cal_pkg::NUM_AMPS-1:0] amp_cal_ref_sel,
  output logic [trim_cal_pkg::AMP_TRIM_W-1:0] amp_offset_trim0,
  output logic [trim_cal_pkg::AMP_TRIM_W-1:0] amp_offset_trim1,
  input wire logic [trim_cal_pkg::NUM_AMPS-1:0] amp_cal_output,
  output logic amp_pin_func_sel,
  output logic cmp_cal_mode_sel,
  output logic cmp_cal_ref_sel,
  output logic [trim_cal_pkg::CMP_TRIM_W-1:0] cmp_offset_trim,
  input wire logic cmp_output_bit
);
  import trim_cal_pkg::*;

  // Refuse a settling count that the timer cannot serve
  if (SETTLE_CYCLES < 1) begin : g_bad_settle
    $error("SETTLE_CYCLES must be at least 1");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  cal_state_e state_q, state_d; // Sequencer state
  cal_state_e after_q, after_d; // State after settling
  logic [1:0] tgt_q, tgt_d; // 0/1 amplifier, 2 comparator
  logic [5:0] code_q, code_d; // Working trim code
  logic [5:0] lo_q, lo_d; // Lower crossing
  logic [5:0] hi_q, hi_d; // Upper crossing
  logic ref_bit_q, ref_bit_d; // Output state before step
  logic done_q, done_d; // Result available
  logic lo_end_q, lo_end_d; // Up sweep hit range end
  logic hi_end_q, hi_end_d; // Down sweep hit range end
  logic mode_q, mode_d; // Mode select drive
  logic rsel_q, rsel_d; // Reference select drive
  logic pin_q, pin_d; // Pin function drive
  logic [5:0] trim_q [NUM_AMPS+1]; // Trim held per stage
  logic [5:0] trim_d [NUM_AMPS+1];
  logic [7:0] rdata_q, rdata_d; // Read data register
  logic settle_go; // Kick settle timer
  logic settle_done; // Settle expired
  logic start_req; // Start command write
  logic cur_bit; // Sampled output of target
  logic [5:0] top_code; // Full scale of target
  logic [6:0] sum; // Crossing sum

  // ----------------------------------------------------------------
  // Output sampling
  // ----------------------------------------------------------------
  // Comparator bit only read, never driven
  assign cur_bit = (tgt_q == TGT_CMP) ? cmp_output_bit
                                      : amp_cal_output[tgt_q[0]];
  assign top_code = (tgt_q == TGT_CMP) ? 6'h1F : 6'h3F;
  assign sum = {1'b0, lo_q} + {1'b0, hi_q};
  assign start_req = wr && (addr == CTRL_OFS) && wdata[CTRL_START_BIT]
                     && (state_q == ST_IDLE)
                     && (wdata[CTRL_TGT_LSB+:2] != 2'h3);

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    after_d = after_q;
    tgt_d = tgt_q;
    code_d = code_q;
    lo_d = lo_q;
    hi_d = hi_q;
    ref_bit_d = ref_bit_q;
    done_d = done_q;
    lo_end_d = lo_end_q;
    hi_end_d = hi_end_q;
    mode_d = mode_q;
    rsel_d = rsel_q;
    pin_d = pin_q;
    settle_go = 1'b0;
    for (int i = 0; i < NUM_AMPS + 1; i++) begin
      trim_d[i] = trim_q[i];
    end
    case (state_q)
      ST_IDLE: begin
        // Accept a new run
        if (start_req) begin
          tgt_d = wdata[CTRL_TGT_LSB+:2];
          done_d = 1'b0;
          lo_end_d = 1'b0;
          hi_end_d = 1'b0;
          // Amplifier inputs switched to analog function first
          pin_d = (wdata[CTRL_TGT_LSB+:2] != TGT_CMP) || pin_q;
          state_d = ST_MODE;
        end
      end
      ST_MODE: begin
        // Mode bit raised alone
        mode_d = 1'b1;
        state_d = ST_REF;
      end
      ST_REF: begin
        // Reference selected only after mode
        rsel_d = 1'b1;
        state_d = ST_ZERO;
      end
      ST_ZERO: begin
        // Start of up sweep from zero
        code_d = 6'h00;
        trim_d[tgt_q] = 6'h00;
        settle_go = 1'b1;
        after_d = ST_UP;
        state_d = ST_SETTLE;
      end
      ST_SETTLE: begin
        // Wait before sampling
        if (settle_done) begin
          state_d = after_q;
          if (after_q == ST_UP && code_q == 6'h00) begin
            ref_bit_d = cur_bit;
            state_d = ST_UP;
            after_d = ST_IDLE;
          end
        end
      end
      ST_UP: begin
        // Evaluate sample after a step, or take first step
        if (after_q == ST_UP && cur_bit != ref_bit_q) begin
          lo_d = code_q;
          state_d = ST_ONES;
        end else if (after_q == ST_UP && code_q == top_code) begin
          lo_d = code_q;
          lo_end_d = 1'b1;
          state_d = ST_ONES;
        end else begin
          code_d = code_q + 6'h01;
          trim_d[tgt_q] = code_q + 6'h01;
          settle_go = 1'b1;
          after_d = ST_UP;
          state_d = ST_SETTLE;
        end
      end
      ST_ONES: begin
        // Start of down sweep from full scale
        code_d = top_code;
        trim_d[tgt_q] = top_code;
        settle_go = 1'b1;
        after_d = ST_ONES;
        state_d = ST_SETTLE;
        if (after_q == ST_ONES) begin
          ref_bit_d = cur_bit;
          after_d = ST_IDLE;
          state_d = ST_DOWN;
          settle_go = 1'b0;
          code_d = code_q;
          trim_d[tgt_q] = trim_q[tgt_q];
        end
      end
      ST_DOWN: begin
        // Evaluate sample after a step, or take first step
        if (after_q == ST_DOWN && cur_bit != ref_bit_q) begin
          hi_d = code_q;
          state_d = ST_FINISH;
        end else if (after_q == ST_DOWN && code_q == 6'h00) begin
          hi_d = code_q;
          hi_end_d = 1'b1;
          state_d = ST_FINISH;
        end else begin
          code_d = code_q - 6'h01;
          trim_d[tgt_q] = code_q - 6'h01;
          settle_go = 1'b1;
          after_d = ST_DOWN;
          state_d = ST_SETTLE;
        end
      end
      ST_FINISH: begin
        // Truncated average restored, calibration mode left
        trim_d[tgt_q] = sum[6:1];
        mode_d = 1'b0;
        rsel_d = 1'b0;
        done_d = 1'b1;
        after_d = ST_IDLE;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
        after_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Settling timer
  // ----------------------------------------------------------------
  settle_timer #(
    .CYCLES(SETTLE_CYCLES)
  ) u_settle (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .start(settle_go),
    .done(settle_done)
  );

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = 8'h00;
    if (rd) begin
      case (addr)
        CTRL_OFS: rdata_d = {5'h00, tgt_q, 1'b0};
        STAT_OFS: rdata_d = {4'h0, hi_end_q, lo_end_q, done_q,
                             (state_q != ST_IDLE)};
        RES_OFS: rdata_d = {2'h0, sum[6:1]};
        TRIM_OFS: rdata_d = {2'h0, trim_q[tgt_q]};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      after_q <= ST_IDLE;
      tgt_q <= 2'h0;
      code_q <= 6'h00;
      lo_q <= 6'h00;
      hi_q <= 6'h00;
      ref_bit_q <= 1'b0;
      done_q <= 1'b0;
      lo_end_q <= 1'b0;
      hi_end_q <= 1'b0;
      mode_q <= 1'b0;
      rsel_q <= 1'b0;
      pin_q <= 1'b0;
      rdata_q <= 8'h00;
      trim_q[0] <= AMP_TRIM_RST;
      trim_q[1] <= AMP_TRIM_RST;
      trim_q[2] <= {1'b0, CMP_TRIM_RST};
    end else begin
      state_q <= state_d;
      after_q <= after_d;
      tgt_q <= tgt_d;
      code_q <= code_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
      ref_bit_q <= ref_bit_d;
      done_q <= done_d;
      lo_end_q <= lo_end_d;
      hi_end_q <= hi_end_d;
      mode_q <= mode_d;
      rsel_q <= rsel_d;
      pin_q <= pin_d;
      rdata_q <= rdata_d;
      for (int i = 0; i < NUM_AMPS + 1; i++) begin
        trim_q[i] <= trim_d[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_AMPS; g++) begin : g_amp
      assign amp_cal_mode_sel[g] = mode_q && (tgt_q == 2'(g));
      assign amp_cal_ref_sel[g] = rsel_q && (tgt_q == 2'(g));
    end
  endgenerate
  assign amp_offset_trim0 = trim_q[0];
  assign amp_offset_trim1 = trim_q[1];
  assign cmp_offset_trim = trim_q[2][4:0];
  assign cmp_cal_mode_sel = mode_q && (tgt_q == TGT_CMP);
  assign cmp_cal_ref_sel = rsel_q && (tgt_q == TGT_CMP);
  assign amp_pin_func_sel = pin_q;
  assign rdata = rdata_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence mode_then_ref_s;
    (state_q == ST_MODE) ##1 (state_q == ST_REF);
  endsequence
  mode_order_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    mode_then_ref_s |=> (mode_q && rsel_q))
    else $error("reference select not after mode");
  ref_needs_mode_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(rsel_q) |-> $past(mode_q))
    else $error("reference raised before mode");
  pin_first_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (|amp_cal_mode_sel) |-> amp_pin_func_sel)
    else $error("amplifier calibrated without pin function");
  zero_start_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_q == ST_ZERO) |=> (code_q == 6'h00))
    else $error("up sweep not started at zero");
  ones_start_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_q == ST_ONES && after_q != ST_ONES) |=> (code_q == top_code))
    else $error("down sweep not started at full scale");
  up_step_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_q == ST_UP && state_d == ST_SETTLE) |=> (code_q == $past(code_q) + 6'h01))
    else $error("up step not by one");
  down_step_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_q == ST_DOWN && state_d == ST_SETTLE) |=> (code_q == $past(code_q) - 6'h01))
    else $error("down step not by one");
  settle_wait_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    settle_go |=> (state_q == ST_SETTLE) [*2])
    else $error("sample taken without settling");
  final_avg_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_q == ST_FINISH) |=> (trim_q[tgt_q] == $past(sum[6:1]) && done_q))
    else $error("final trim not the halved sum");
  range_stop_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_q == ST_SETTLE) |-> (code_q <= top_code))
    else $error("sweep left the trim range");
endmodule // trim_cal_ctrl

// ==== testbench/trim_stage_model.sv ====
// Behavioural model of the amplifier and comparator trim stages
`timescale 1ns/1ps
module trim_stage_model #(
  parameter int DLY = 3
) (
  input wire logic ref_clk,
  input wire logic [1:0] amp_cal_mode_sel,
  input wire logic [1:0] amp_cal_ref_sel,
  input wire logic [5:0] amp_offset_trim0,
  input wire logic [5:0] amp_offset_trim1,
  input wire logic cmp_cal_mode_sel,
  input wire logic cmp_cal_ref_sel,
  input wire logic [4:0] cmp_offset_trim,
  input wire logic [6:0] thr0,
  input wire logic [6:0] thr1,
  input wire logic [6:0] thr2,
  input wire logic [2:0] inv,
  output logic [1:0] amp_cal_output,
  output logic cmp_output_bit
);
  // ------------------------------------------------------------
  // Ideal stage outputs and their settling lag
  // ------------------------------------------------------------
  logic [2:0] ideal; // Settled output of each stage
  logic [2:0] pipe [DLY]; // Lag line, early samples see stale levels
  logic [2:0] junk_q = 3'h5; // Changes every cycle outside calibration
  // Output flips where the trim code passes the offset threshold
  always_comb begin
    ideal[0] = ({1'b0, amp_offset_trim0} >= thr0) ^ inv[0];
    ideal[1] = ({1'b0, amp_offset_trim1} >= thr1) ^ inv[1];
    ideal[2] = ({2'h0, cmp_offset_trim} >= thr2) ^ inv[2];
  end
  // Settling lag and the undefined level outside calibration
  always @(posedge ref_clk) begin
    pipe[0] <= ideal;
    for (int i = 1; i < DLY; i++) begin
      pipe[i] <= pipe[i-1];
    end
    junk_q <= ~junk_q ^ {junk_q[1:0], 1'b0};
  end
  // Each amplifier has its own bit, meaningful only in calibration
  assign amp_cal_output[0] = (amp_cal_mode_sel[0] & amp_cal_ref_sel[0]) ?
    pipe[DLY-1][0] : junk_q[0];
  assign amp_cal_output[1] = (amp_cal_mode_sel[1] & amp_cal_ref_sel[1]) ?
    pipe[DLY-1][1] : junk_q[1];
  assign cmp_output_bit = (cmp_cal_mode_sel & cmp_cal_ref_sel) ?
    pipe[DLY-1][2] : junk_q[2];
endmodule // trim_stage_model

// ==== testbench/tb.sv ====
// Self-checking bench for the offset trim calibration controller
`timescale 1ns/1ps
module tb;
  import trim_cal_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int SC = 4; // Shortened settling count
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [1:0] amp_mode, amp_ref, amp_out;
  logic [5:0] trim0, trim1;
  logic [4:0] trim2;
  logic pin_sel, cmp_mode, cmp_ref, cmp_out;
  logic [6:0] thr [3] = '{7'h00, 7'h00, 7'h00}; // Stage thresholds
  logic [2:0] inv = 3'h0; // Stage output polarity
  logic [7:0] cur [3] = '{8'h20, 8'h20, 8'h10}; // Expected trims
  int n_errors = 0;
  int checks = 0;
  // Clock at 200 MHz
  always #2.5 ref_clk = ~ref_clk;
  trim_cal_ctrl #(.SETTLE_CYCLES(SC)) i_dut (.ref_clk(ref_clk),
    .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .amp_cal_mode_sel(amp_mode), .amp_cal_ref_sel(amp_ref),
    .amp_offset_trim0(trim0), .amp_offset_trim1(trim1),
    .amp_cal_output(amp_out), .amp_pin_func_sel(pin_sel),
    .cmp_cal_mode_sel(cmp_mode), .cmp_cal_ref_sel(cmp_ref),
    .cmp_offset_trim(trim2), .cmp_output_bit(cmp_out));
  // Stage model lags by the full settling count
  trim_stage_model #(.DLY(SC)) i_stage (.ref_clk(ref_clk),
    .amp_cal_mode_sel(amp_mode), .amp_cal_ref_sel(amp_ref),
    .amp_offset_trim0(trim0), .amp_offset_trim1(trim1),
    .cmp_cal_mode_sel(cmp_mode), .cmp_cal_ref_sel(cmp_ref),
    .cmp_offset_trim(trim2), .thr0(thr[0]), .thr1(thr[1]), .thr2(thr[2]),
    .inv(inv), .amp_cal_output(amp_out), .cmp_output_bit(cmp_out));
  // ------------------------------------------------------------
  // Tasks and expectation functions
  // ------------------------------------------------------------
  // Verdict and end of run
  task automatic end_sim();
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Compare one byte
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One-cycle register write
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // One-cycle read, data taken in the following cycle
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // Crossings of a sweep over 0..top against threshold t
  function automatic void exp_cal(input int t, input int top,
      output int lo, output int hi, output bit lo_e, output bit hi_e);
    lo = top;
    hi = 0;
    lo_e = 1'b1;
    hi_e = 1'b1;
    for (int c = top; c >= 1; c--) begin
      if ((c >= t) != (0 >= t)) begin
        lo = c;
        lo_e = 1'b0;
      end
    end
    for (int c = 0; c < top; c++) begin
      if ((c >= t) != (top >= t)) begin
        hi = c;
        hi_e = 1'b0;
      end
    end
  endfunction
  // Full calibration of one target with threshold t
  task automatic run_cal(input int tgt, input int t);
    logic [7:0] v;
    logic [7:0] sel;
    int lo, hi, n;
    bit lo_e, hi_e;
    thr[tgt] <= 7'(t);
    inv <= 3'($urandom);
    exp_cal(t, (tgt == 2) ? 31 : 63, lo, hi, lo_e, hi_e);
    wr_reg(CTRL_OFS, 8'((tgt << CTRL_TGT_LSB) | 1));
    repeat (8) @(posedge ref_clk);
    #1;
    sel = (tgt == 2) ? 8'h30 : 8'({2'(1 << tgt), 2'(1 << tgt)});
    chk({2'h0, cmp_mode, cmp_ref, amp_mode, amp_ref}, sel);
    if (tgt < 2) begin
      chk({7'h0, pin_sel}, 8'h01);
    end
    wr_reg(CTRL_OFS, 8'((((tgt + 1) % 3) << CTRL_TGT_LSB) | 1));
    rd_reg(CTRL_OFS, v);
    chk(v, 8'(tgt << CTRL_TGT_LSB));
    rd_reg(STAT_OFS, v);
    chk({6'h0, v[STAT_DONE_BIT], v[STAT_BUSY_BIT]}, 8'h01);
    n = 0;
    do begin
      rd_reg(STAT_OFS, v);
      n++;
    end while (v[STAT_BUSY_BIT] !== 1'b0 && n < 3000);
    if (v[STAT_BUSY_BIT] !== 1'b0) begin
      n_errors++;
      end_sim();
    end
    chk(v, 8'({hi_e, lo_e, 2'b10}));
    cur[tgt] = 8'((lo + hi) / 2);
    rd_reg(RES_OFS, v);
    chk(v, cur[tgt]);
    rd_reg(TRIM_OFS, v);
    chk(v, cur[tgt]);
    chk({2'h0, trim0}, cur[0]);
    chk({2'h0, trim1}, cur[1]);
    chk({3'h0, trim2}, cur[2]);
    chk({2'h0, cmp_mode, cmp_ref, amp_mode, amp_ref}, 8'h00);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] v;
    int tgt;
    void'($urandom(35));
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk({2'h0, trim0}, 8'h20);
    chk({2'h0, trim1}, 8'h20);
    chk({3'h0, trim2}, 8'h10);
    chk(rdata, 8'h00);
    rd_reg(4'h9, v);
    chk(v, 8'h00);
    wr_reg(CTRL_OFS, 8'h07);
    repeat (3) @(posedge ref_clk);
    rd_reg(STAT_OFS, v);
    chk({7'h0, v[STAT_BUSY_BIT]}, 8'h00);
    chk({3'h0, trim2}, 8'h10);
    run_cal(0, 0);
    run_cal(1, 64);
    run_cal(2, 1);
    run_cal(0, 63);
    run_cal(2, 31);
    run_cal(2, 32);
    // Reset in mid-run returns trims and selects to idle values
    wr_reg(CTRL_OFS, 8'h05);
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    #1;
    cur = '{8'h20, 8'h20, 8'h10};
    chk({2'h0, trim0}, cur[0]);
    chk({2'h0, trim1}, cur[1]);
    chk({3'h0, trim2}, cur[2]);
    chk({2'h0, cmp_mode, cmp_ref, amp_mode, amp_ref}, 8'h00);
    rd_reg(STAT_OFS, v);
    chk(v, 8'h00);
    repeat (6) begin
      tgt = int'($urandom % 3);
      run_cal(tgt, int'($urandom % ((tgt == 2) ? 33 : 65)));
    end
    end_sim();
  end
endmodule // tb
